// ---- inc/ipr6_pkg.sv ----
package ipr6_pkg;
    localparam int unsigned IPR6_AW = 4;
    localparam int unsigned IPR6_DW = 32;
    localparam int unsigned IPR6_PW = 3;
    // Register byte offsets on the bus
    localparam logic [3:0] IPR6_OFF_CTRL = 4'h0;
    localparam logic [3:0] IPR6_OFF_LEVEL = 4'h4;
    localparam logic [3:0] IPR6_OFF_PEND = 4'h8;
    // Field positions inside the priority register
    localparam int unsigned IPR6_DMA2_LSB = 0;
    localparam int unsigned IPR6_OC3_LSB = 4;
    localparam int unsigned IPR6_OC4_LSB = 8;
    localparam int unsigned IPR6_T4_LSB = 12;
    localparam logic [15:0] IPR6_IMPL_MASK = 16'h7777;
    localparam logic [2:0] IPR6_PRIO_RESET = 3'h4;
    localparam logic [15:0] IPR6_CTRL_RESET = 16'h4444;
    localparam logic [2:0] IPR6_PRIO_OFF = 3'h0;
    localparam logic [31:0] IPR6_UNMAPPED_DATA = 32'h0000_0000;
    typedef enum logic [1:0] {
        IPR6_IDLE = 2'b00,
        IPR6_DONE = 2'b01
    } ipr6_state_t;
endpackage

// ---- hdl/ipr6_regs.sv ----
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module ipr6_regs
    import ipr6_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Avalon-MM slave
    input wire logic [IPR6_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [IPR6_DW-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [IPR6_DW-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt source flags
    input wire logic [3:0] src_flag,
    // Priority fields to the arbiter
    output logic [2:0] timer_four_priority,
    output logic [2:0] compare_four_priority,
    output logic [2:0] compare_three_priority,
    output logic [2:0] dma_two_done_priority,
    // Gated requests, one per source: dma2, oc3, oc4, t4
    output logic [3:0] src_request
);
    logic [15:0] interrupt_priority_control_six_r, ctrl_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic wait_r, wait_nxt;
    ipr6_state_t state_r, state_nxt;
    logic [3:0] req_r, req_nxt;
    logic [2:0] level_r, level_nxt;
    logic [2:0] fld [4];

    function automatic logic [2:0] field_of(input logic [15:0] v, input int unsigned lsb);
        field_of = v[lsb +: 3];
    endfunction

    assign fld[0] = field_of(interrupt_priority_control_six_r, IPR6_DMA2_LSB);
    assign fld[1] = field_of(interrupt_priority_control_six_r, IPR6_OC3_LSB);
    assign fld[2] = field_of(interrupt_priority_control_six_r, IPR6_OC4_LSB);
    assign fld[3] = field_of(interrupt_priority_control_six_r, IPR6_T4_LSB);

    // Gate each source: a zero field never requests
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_req
            assign req_nxt[g] = src_flag[g] && (fld[g] != IPR6_PRIO_OFF);
        end
    endgenerate

    // Highest active level; field code equals level directly
    always_comb begin
        level_nxt = IPR6_PRIO_OFF;
        for (int i = 0; i < 4; i++) begin
            if (req_nxt[i] && fld[i] > level_nxt) begin
                level_nxt = fld[i];
            end
        end
    end

    // Bus: one wait cycle, answer on the second edge; simple and keeps readdata registered
    always_comb begin
        ctrl_nxt = interrupt_priority_control_six_r;
        rdata_nxt = rdata_r;
        wait_nxt = 1'b1;
        state_nxt = state_r;
        case (state_r)
            IPR6_IDLE: begin
                if (avs_read || avs_write) begin
                    state_nxt = IPR6_DONE;
                    wait_nxt = 1'b0;
                    if (avs_write && avs_address == IPR6_OFF_CTRL) begin
                        for (int b = 0; b < 2; b++) begin
                            if (avs_byteenable[b]) begin
                                ctrl_nxt[b*8 +: 8] = avs_writedata[b*8 +: 8] & IPR6_IMPL_MASK[b*8 +: 8];
                            end
                        end
                    end
                    if (avs_read) begin
                        if (avs_address == IPR6_OFF_CTRL) begin
                            rdata_nxt = {16'h0000, interrupt_priority_control_six_r & IPR6_IMPL_MASK};
                        end else if (avs_address == IPR6_OFF_LEVEL) begin
                            rdata_nxt = {29'h0, level_r};
                        end else if (avs_address == IPR6_OFF_PEND) begin
                            rdata_nxt = {28'h000_0000, req_r};
                        end else begin
                            rdata_nxt = IPR6_UNMAPPED_DATA;
                        end
                    end
                end
            end
            IPR6_DONE: begin
                state_nxt = IPR6_IDLE;
            end
            default: begin
                state_nxt = IPR6_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            interrupt_priority_control_six_r <= IPR6_CTRL_RESET;
            rdata_r <= 32'h0000_0000;
            wait_r <= 1'b1;
            state_r <= IPR6_IDLE;
            req_r <= 4'h0;
            level_r <= 3'h0;
        end else begin
            interrupt_priority_control_six_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
            wait_r <= wait_nxt;
            state_r <= state_nxt;
            req_r <= req_nxt;
            level_r <= level_nxt;
        end
    end

    assign avs_readdata = rdata_r;
    assign avs_waitrequest = wait_r;
    assign src_request = req_r;
    assign timer_four_priority = interrupt_priority_control_six_r[IPR6_T4_LSB +: 3];
    assign compare_four_priority = interrupt_priority_control_six_r[IPR6_OC4_LSB +: 3];
    assign compare_three_priority = interrupt_priority_control_six_r[IPR6_OC3_LSB +: 3];
    assign dma_two_done_priority = interrupt_priority_control_six_r[IPR6_DMA2_LSB +: 3];

    property p_unimpl_zero;
        @(posedge clk) disable iff (!reset_n)
        (interrupt_priority_control_six_r & ~IPR6_IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("Unimplemented bit set");

    property p_disabled_quiet;
        @(posedge clk) disable iff (!reset_n)
        (fld[0] == IPR6_PRIO_OFF) |=> !req_r[0] || $past(fld[0]) != IPR6_PRIO_OFF;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("Disabled source requested");

    property p_top_level;
        @(posedge clk) disable iff (!reset_n)
        (src_flag[3] && fld[3] == 3'h7) |=> level_r == 3'h7;
    endproperty
    a_top_level: assert property (p_top_level) else $error("Level seven not reported");

    property p_low_level;
        @(posedge clk) disable iff (!reset_n)
        (req_nxt == 4'h1 && fld[0] == 3'h1) |=> level_r == 3'h1;
    endproperty
    a_low_level: assert property (p_low_level) else $error("Level one not reported");

    property p_oc4_write;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && avs_byteenable[1])
            |=> compare_four_priority == $past(avs_writedata[10:8]);
    endproperty
    a_oc4_write: assert property (p_oc4_write) else $error("Channel four field not written");

    property p_oc3_write;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && avs_byteenable[0])
            |=> compare_three_priority == $past(avs_writedata[6:4]);
    endproperty
    a_oc3_write: assert property (p_oc3_write) else $error("Channel three field not written");

    property p_reset_value;
        @(posedge clk) $rose(reset_n) |-> interrupt_priority_control_six_r == IPR6_CTRL_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("Wrong reset value");

    property p_answer;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && (avs_read || avs_write)) |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("Bus answer timing wrong");

    property p_t4_write;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && avs_byteenable[1])
            |=> timer_four_priority == $past(avs_writedata[14:12]);
    endproperty
    a_t4_write: assert property (p_t4_write) else $error("Timer four field not written");

    property p_dma2_write;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && avs_byteenable[0])
            |=> dma_two_done_priority == $past(avs_writedata[2:0]);
    endproperty
    a_dma2_write: assert property (p_dma2_write) else $error("Channel two field not written");

    property p_high_lane_kept;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && !avs_byteenable[1])
            |=> $stable(interrupt_priority_control_six_r[15:8]);
    endproperty
    a_high_lane_kept: assert property (p_high_lane_kept) else $error("Disabled upper lane changed");

    property p_low_lane_kept;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL && !avs_byteenable[0])
            |=> $stable(interrupt_priority_control_six_r[7:0]);
    endproperty
    a_low_lane_kept: assert property (p_low_lane_kept) else $error("Disabled lower lane changed");

    // Only a taken write at the register offset may change it
    property p_other_kept;
        @(posedge clk) disable iff (!reset_n)
        !(state_r == IPR6_IDLE && avs_write && avs_address == IPR6_OFF_CTRL)
            |=> $stable(interrupt_priority_control_six_r);
    endproperty
    a_other_kept: assert property (p_other_kept) else $error("Register changed without a write");

    // No disable here: these watch the reset itself
    property p_reset_quiet;
        @(posedge clk)
        !reset_n |=> avs_waitrequest && src_request == 4'h0 && avs_readdata == 32'h0000_0000;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("Bus or requests active in reset");

    property p_reset_load;
        @(posedge clk)
        !reset_n |=> interrupt_priority_control_six_r == IPR6_CTRL_RESET;
    endproperty
    a_reset_load: assert property (p_reset_load) else $error("Register not loaded in reset");

    property p_oc3_gate;
        @(posedge clk) disable iff (!reset_n)
        (fld[1] == IPR6_PRIO_OFF) |=> !req_r[1];
    endproperty
    a_oc3_gate: assert property (p_oc3_gate) else $error("Disabled channel three requested");

    property p_oc4_gate;
        @(posedge clk) disable iff (!reset_n)
        (fld[2] == IPR6_PRIO_OFF) |=> !req_r[2];
    endproperty
    a_oc4_gate: assert property (p_oc4_gate) else $error("Disabled channel four requested");

    property p_t4_gate;
        @(posedge clk) disable iff (!reset_n)
        (fld[3] == IPR6_PRIO_OFF) |=> !req_r[3];
    endproperty
    a_t4_gate: assert property (p_t4_gate) else $error("Disabled timer four requested");

    property p_dma2_level;
        @(posedge clk) disable iff (!reset_n)
        req_nxt[0] |=> level_r >= $past(fld[0]);
    endproperty
    a_dma2_level: assert property (p_dma2_level) else $error("Level below channel two");

    property p_oc3_level;
        @(posedge clk) disable iff (!reset_n)
        req_nxt[1] |=> level_r >= $past(fld[1]);
    endproperty
    a_oc3_level: assert property (p_oc3_level) else $error("Level below channel three");

    property p_oc4_level;
        @(posedge clk) disable iff (!reset_n)
        req_nxt[2] |=> level_r >= $past(fld[2]);
    endproperty
    a_oc4_level: assert property (p_oc4_level) else $error("Level below channel four");

    property p_t4_level;
        @(posedge clk) disable iff (!reset_n)
        req_nxt[3] |=> level_r >= $past(fld[3]);
    endproperty
    a_t4_level: assert property (p_t4_level) else $error("Level below timer four");

    property p_level_idle;
        @(posedge clk) disable iff (!reset_n)
        (req_nxt == 4'h0) |=> level_r == 3'h0;
    endproperty
    a_level_idle: assert property (p_level_idle) else $error("Level shown with no request");

    property p_ctrl_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_read && avs_address == IPR6_OFF_CTRL)
            |=> avs_readdata == {16'h0000, $past(interrupt_priority_control_six_r)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("Register read data wrong");

    property p_unimpl_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_read && avs_address == IPR6_OFF_CTRL)
            |=> (avs_readdata[15:0] & ~IPR6_IMPL_MASK) == 16'h0000;
    endproperty
    a_unimpl_read: assert property (p_unimpl_read) else $error("Unimplemented bit read as one");

    property p_level_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_read && avs_address == IPR6_OFF_LEVEL)
            |=> avs_readdata == {29'h0, $past(level_r)};
    endproperty
    a_level_read: assert property (p_level_read) else $error("Level read data wrong");

    property p_pend_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_read && avs_address == IPR6_OFF_PEND)
            |=> avs_readdata == {28'h0, $past(src_request)};
    endproperty
    a_pend_read: assert property (p_pend_read) else $error("Pending read data wrong");

    property p_unmapped_read;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_IDLE && avs_read && avs_address != IPR6_OFF_CTRL
            && avs_address != IPR6_OFF_LEVEL && avs_address != IPR6_OFF_PEND)
            |=> avs_readdata == IPR6_UNMAPPED_DATA;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("Unmapped read not zero");

    property p_wait_state;
        @(posedge clk) disable iff (!reset_n)
        (state_r == IPR6_DONE) == (!avs_waitrequest);
    endproperty
    a_wait_state: assert property (p_wait_state) else $error("Waitrequest out of step with state");
endmodule

// ---- test/ipr6_regs_tb.sv ----
`timescale 1ns/1ns
module ipr6_regs_tb
    import ipr6_pkg::*;
;
    typedef struct packed {logic [15:0] wd; logic [3:0] be; logic [15:0] exp;} ipr6_row_t;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [IPR6_AW-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [IPR6_DW-1:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [IPR6_DW-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] src_flag = 4'h0;
    logic [2:0] timer_four_priority, compare_four_priority, compare_three_priority, dma_two_done_priority;
    logic [3:0] src_request;
    logic [31:0] rd;
    int fail_count = 0;
    int tests_run = 0;
    // Byte-lane rows run in order; the last three, with partial byte enables, build on the one before
    ipr6_row_t rows [6] = '{'{16'hffff, 4'h3, 16'h7777}, '{16'h0000, 4'h3, 16'h0000},
        '{16'h1111, 4'h3, 16'h1111}, '{16'h7654, 4'h1, 16'h1154}, '{16'h3a10, 4'h2, 16'h3254},
        '{16'h2536, 4'hc, 16'h3254}};
    wire logic [31:0] fields = {17'h0, timer_four_priority, 1'b0, compare_four_priority, 1'b0,
        compare_three_priority, 1'b0, dma_two_done_priority};

    ipr6_regs DUT (.clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .src_flag, .timer_four_priority, .compare_four_priority,
        .compare_three_priority, .dma_two_done_priority, .src_request);

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One idle edge first, so a release and the next request never share a time step
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_read <= ~is_wr;
        avs_write <= is_wr;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        check("answer edge", n, 32'd2);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        #50000;
        fail_count++;
        $display("watchdog expired");
        complete_run();
    end

    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        bus(1'b0, IPR6_OFF_CTRL, 32'h0, 4'hf);
        check("reset value", rd, 32'h0000_4444);
        check("reset fields", fields, 32'h0000_4444);
        $display("test reset done");
        foreach (rows[i]) begin
            bus(1'b1, IPR6_OFF_CTRL, {16'hffff, rows[i].wd}, rows[i].be);
            bus(1'b0, IPR6_OFF_CTRL, 32'h0, 4'hf);
            check("priority register", rd, {16'h0, rows[i].exp});
            check("priority fields", fields, {16'h0, rows[i].exp});
        end
        $display("test lanes done");
        // Only compare three and timer four are enabled, both at the top level
        bus(1'b1, IPR6_OFF_CTRL, 32'h0000_7070, 4'h3);
        src_flag <= 4'hf;
        repeat (3) @(posedge clk);
        check("requests off", {28'h0, src_request}, 32'ha);
        bus(1'b0, IPR6_OFF_LEVEL, 32'h0, 4'hf);
        check("level seven", rd, 32'h7);
        bus(1'b1, IPR6_OFF_CTRL, 32'h0000_1001, 4'h3);
        repeat (3) @(posedge clk);
        check("requests low", {28'h0, src_request}, 32'h9);
        bus(1'b0, IPR6_OFF_LEVEL, 32'h0, 4'hf);
        check("level one", rd, 32'h1);
        src_flag <= 4'h1;
        repeat (3) @(posedge clk);
        check("request dma only", {28'h0, src_request}, 32'h1);
        bus(1'b0, IPR6_OFF_LEVEL, 32'h0, 4'hf);
        check("level one alone", rd, 32'h1);
        src_flag <= 4'h0;
        $display("test requests done");
        bus(1'b1, 4'hc, 32'hffff_ffff, 4'hf);
        bus(1'b0, 4'hc, 32'h0, 4'hf);
        check("unmapped read", rd, 32'h0);
        bus(1'b0, IPR6_OFF_CTRL, 32'h0, 4'hf);
        check("after unmapped write", rd, 32'h0000_1001);
        $display("test unmapped done");
        // Reset again in mid-run, with sources active
        bus(1'b1, IPR6_OFF_CTRL, 32'h0000_7777, 4'h3);
        src_flag <= 4'hf;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        check("reset fields again", fields, 32'h0000_4444);
        check("reset requests", {28'h0, src_request}, 32'h0);
        check("reset readdata", avs_readdata, 32'h0);
        check("reset waitrequest", {31'h0, avs_waitrequest}, 32'h1);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
        check("requests after reset", {28'h0, src_request}, 32'hf);
        src_flag <= 4'h0;
        $display("test reset again done");
        complete_run();
    end
endmodule
